// File: core/nfs_defines.svh
// Constants of the NAND host sequencer: pin timing, command bytes, layout
// Assumes a 4 ns system clock; long busy limits become top-level parameters
`ifndef NFS_DEFINES_SVH
`define NFS_DEFINES_SVH
`define NFS_CLK_NS    4
// Strobe low and high phases of one bus beat
`define NFS_LO_NS     40
`define NFS_HI_NS     20
`define NFS_LO_CYC    ((`NFS_LO_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
`define NFS_HI_CYC    ((`NFS_HI_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
// Read byte is taken this many cycles into the beat
`define NFS_SMP_CYC   (`NFS_LO_CYC + 1)
// Gap between last address and first data beat, also used for turnarounds
`define NFS_ADL_NS    100
`define NFS_ADL_CYC   ((`NFS_ADL_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS)
// Strobe-high-to-busy wait, plus pin register and synchroniser latency
`define NFS_WB_NS     100
`define NFS_SYNC_CYC  4
`define NFS_WB_CYC    ((`NFS_WB_NS + `NFS_CLK_NS - 1) / `NFS_CLK_NS + `NFS_SYNC_CYC)
// Longest busy times
`define NFS_READ_US   25
`define NFS_PROG_US   700
`define NFS_ERASE_US  2000
`define NFS_RST_US    500
// Command bytes
`define NFS_CMD_RD1   8'h00
`define NFS_CMD_RD2   8'h30
`define NFS_CMD_PG1   8'h80
`define NFS_CMD_PG2   8'h10
`define NFS_CMD_ER1   8'h60
`define NFS_CMD_ER2   8'hd0
`define NFS_CMD_STAT  8'h70
`define NFS_CMD_RST   8'hff
// Layout and limits
`define NFS_MARK_COL  12'h800
`define NFS_ERASED    8'hff
`define NFS_ST_FAIL   0
`define NFS_NOP_MAX   3'h4
`define NFS_ECC_LAST  9'h1ff
`define NFS_NBLK      2048
`endif

// File: core/nfs_pkg.sv
// Types shared by the NAND host sequencer and its bench
// Assumes nfs_defines.svh holds every number other than the enum codes below
package nfs_pkg;
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_PROG  = 3'h1,
    OP_ERASE = 3'h2,
    OP_RESET = 3'h3,
    OP_SCAN  = 3'h4
  } nfs_op_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_CMD1  = 4'h1,
    S_ADDR  = 4'h3,
    S_GAP   = 4'h2,
    S_WDAT  = 4'h6,
    S_CMD2  = 4'h7,
    S_WB    = 4'h5,
    S_BUSY  = 4'h4,
    S_RDAT  = 4'hc,
    S_STCMD = 4'hd,
    S_STRD  = 4'hf,
    S_DONE  = 4'he
  } nfs_state_t;
endpackage

// File: core/nfs_ecc.sv
// Hamming code generator: 24-bit code over each run of 512 bytes
// Assumes bytes arrive one per in_valid cycle; clr restarts a run
`timescale 1ns/100ps
`default_nettype none
`include "nfs_defines.svh"
module nfs_ecc (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Byte stream
  input  wire logic        clr,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_byte,
  // Code
  output logic      [23:0] code,
  output logic             code_valid
);
  logic [8:0] idx_r;
  logic [8:0] lpo_r;
  logic [8:0] lpe_r;
  logic [2:0] cpo_r;
  logic [2:0] cpe_r;
  logic [8:0] lpo_nxt;
  logic [8:0] lpe_nxt;
  logic [2:0] cpo_nxt;
  logic [2:0] cpe_nxt;
  wire        bp   = ^in_byte;
  wire        wrap = in_valid & (idx_r == `NFS_ECC_LAST);

  // Parity of the bits whose index has bit k equal to sel
  function automatic logic col_par(input logic [7:0] b, input int k, input logic sel);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i[k] == sel) p = p ^ b[i];
    end
    return p;
  endfunction

  for (genvar g = 0; g < 9; g++) begin : g_line
    assign lpo_nxt[g] = lpo_r[g] ^ (bp & idx_r[g]);
    assign lpe_nxt[g] = lpe_r[g] ^ (bp & ~idx_r[g]);
  end
  for (genvar g = 0; g < 3; g++) begin : g_col
    assign cpo_nxt[g] = cpo_r[g] ^ col_par(in_byte, g, 1'b1);
    assign cpe_nxt[g] = cpe_r[g] ^ col_par(in_byte, g, 1'b0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {idx_r, lpo_r, lpe_r, cpo_r, cpe_r} <= 33'h0;
      code       <= 24'h0;
      code_valid <= 1'b0;
    end else if (ce) begin
      code_valid <= wrap & ~clr;
      if (clr | wrap) {idx_r, lpo_r, lpe_r, cpo_r, cpe_r} <= 33'h0;
      else if (in_valid) begin
        idx_r <= idx_r + 9'h1;
        {lpo_r, lpe_r, cpo_r, cpe_r} <= {lpo_nxt, lpe_nxt, cpo_nxt, cpe_nxt};
      end
      if (wrap & ~clr) code <= {lpo_nxt, lpe_nxt, cpo_nxt, cpe_nxt};
    end
  end
endmodule
`default_nettype wire

// File: core/nfs_host.sv
// Host-side NAND flash sequencer: read, program, erase, reset, mark scan
// Assumes an 8-bit asynchronous NAND on the pins; io and rb_n are async
`timescale 1ns/100ps
`default_nettype none
`include "nfs_defines.svh"
// Behaviour
// - At most 4 partial programs to one page between block erases; only the most recently programmed page is counted.
// - At least 100 ns from last address strobe to first data strobe.
// - Latch and select controls change at most once per write strobe low.
// - Never erase the factory invalid-block mark; erase is refused only for blocks marked bad by a scan or failed status.
// - Keep a table of invalid blocks and map them out.
// - On a failed program or erase status, retire the block.
// - Check all read data with an error-correcting code; the code only generates a 24-bit code per 512 bytes and checks nothing.
// - Correct single-bit errors by code rather than block retirement; no correction is done.
module nfs_host #(
  parameter int unsigned P_READ_CYC  = `NFS_READ_US * 1000 / `NFS_CLK_NS,
  parameter int unsigned P_PROG_CYC  = `NFS_PROG_US * 1000 / `NFS_CLK_NS,
  parameter int unsigned P_ERASE_CYC = `NFS_ERASE_US * 1000 / `NFS_CLK_NS,
  parameter int unsigned P_RST_CYC   = `NFS_RST_US * 1000 / `NFS_CLK_NS
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Command port
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire nfs_pkg::nfs_op_t cmd_op,
  input  wire logic [10:0]      cmd_block,
  input  wire logic [5:0]       cmd_page,
  input  wire logic [11:0]      cmd_col,
  input  wire logic [11:0]      cmd_len,
  // Program data
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [7:0]       wr_data,
  // Read data
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  // Result
  output logic                  done,
  output logic                  res_fail,
  output logic                  res_timeout,
  output logic                  res_refused,
  // Error-correcting code
  output logic [23:0]           ecc_code,
  output logic                  ecc_valid,
  // Flash pins
  output logic                  cle,
  output logic                  ale,
  output logic                  ce_n,
  output logic                  we_n,
  output logic                  read_strobe_n,
  output logic                  wp_n,
  output logic [7:0]            io_out,
  output logic                  io_oe,
  input  wire logic [7:0]       io_in,
  input  wire logic             rb_n
);
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_q;
  logic [7:0] io_q1;
  logic [7:0] io_s;
  logic       rb_q1;
  logic       rb_s;
  wire        rst_s_n = rst_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_q <= 2'h0;
    else if (ce) rst_q <= {rst_q[0], 1'b1};
  end
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {io_q1, io_s} <= 16'h0;
      {rb_q1, rb_s} <= 2'h0;
    end else if (ce) begin
      {io_q1, io_s} <= {io_in, io_q1};
      {rb_q1, rb_s} <= {rb_n, rb_q1};
    end
  end

  // ****************************************
  // State and decode
  // ****************************************
  nfs_pkg::nfs_state_t st_r;
  nfs_pkg::nfs_state_t st_nxt;
  nfs_pkg::nfs_op_t    op_r;
  logic [10:0]         blk_r;
  logic [5:0]          page_r;
  logic [11:0]         col_r;
  logic [11:0]         last_r;
  logic [11:0]         cnt_r;
  logic [11:0]         cnt_nxt;
  logic [4:0]          ph_r;
  logic [19:0]         wt_r;
  logic [19:0]         wt_nxt;
  logic                stat_r;
  logic                stat_nxt;
  logic                tmo_nxt;
  logic [7:0]          wd_r;
  logic [16:0]         nop_addr_r;
  logic [2:0]          nop_cnt_r;
  logic                bad_tbl [`NFS_NBLK];

  function automatic logic is_pe(input nfs_pkg::nfs_op_t op);
    return (op == nfs_pkg::OP_PROG) | (op == nfs_pkg::OP_ERASE);
  endfunction

  wire idle    = st_r == nfs_pkg::S_IDLE;
  wire wr_st   = (st_r == nfs_pkg::S_CMD1) | (st_r == nfs_pkg::S_ADDR) |
                 (st_r == nfs_pkg::S_WDAT) | (st_r == nfs_pkg::S_CMD2) |
                 (st_r == nfs_pkg::S_STCMD);
  wire rd_st   = (st_r == nfs_pkg::S_RDAT) | (st_r == nfs_pkg::S_STRD);
  wire lo      = ph_r < 5'(`NFS_LO_CYC);
  wire ph_end  = ph_r == 5'(`NFS_LO_CYC + `NFS_HI_CYC - 1);
  wire smp     = rd_st & (ph_r == 5'(`NFS_SMP_CYC));
  wire wt_end  = wt_r == 20'h0;
  wire stall   = (st_r == nfs_pkg::S_WDAT) & (ph_r == 5'h0) & ~wr_valid;
  wire take    = ce & cmd_valid & cmd_ready;
  wire wr_take = ce & wr_valid & wr_ready;
  wire rd_take = smp & (st_r == nfs_pkg::S_RDAT);
  wire same_pg = {cmd_block, cmd_page} == nop_addr_r;
  wire refuse  = (cmd_op > nfs_pkg::OP_SCAN) |
                 (is_pe(cmd_op) & bad_tbl[cmd_block]) |
                 ((cmd_op == nfs_pkg::OP_PROG) & same_pg &
                  (nop_cnt_r >= `NFS_NOP_MAX));
  wire mark_bad = ce & smp & (((op_r == nfs_pkg::OP_SCAN) & (io_s != `NFS_ERASED)) |
                  ((st_r == nfs_pkg::S_STRD) & io_s[`NFS_ST_FAIL]));
  wire [19:0] busy_lim =
    (op_r == nfs_pkg::OP_PROG)  ? 20'(P_PROG_CYC) :
    (op_r == nfs_pkg::OP_ERASE) ? 20'(P_ERASE_CYC) :
    (op_r == nfs_pkg::OP_RESET) ? 20'(P_RST_CYC) : 20'(P_READ_CYC);

  assign cmd_ready = idle & rb_s;
  assign wr_ready  = (st_r == nfs_pkg::S_WDAT) & (ph_r == 5'h0);
  assign done      = ce & (st_r == nfs_pkg::S_DONE) & wt_end;

  // ****************************************
  // Bytes put on the bus
  // ****************************************
  wire [7:0] addr_byte =
    (cnt_r[2:0] == 3'h0) ? col_r[7:0] :
    (cnt_r[2:0] == 3'h1) ? {4'h0, col_r[11:8]} :
    (cnt_r[2:0] == 3'h2) ? {blk_r[1:0], page_r} :
    (cnt_r[2:0] == 3'h3) ? blk_r[9:2] : {7'h0, blk_r[10]};
  wire [7:0] cmd1_byte =
    (op_r == nfs_pkg::OP_PROG)  ? `NFS_CMD_PG1 :
    (op_r == nfs_pkg::OP_ERASE) ? `NFS_CMD_ER1 :
    (op_r == nfs_pkg::OP_RESET) ? `NFS_CMD_RST : `NFS_CMD_RD1;
  wire [7:0] cmd2_byte =
    (op_r == nfs_pkg::OP_PROG)  ? `NFS_CMD_PG2 :
    (op_r == nfs_pkg::OP_ERASE) ? `NFS_CMD_ER2 : `NFS_CMD_RD2;
  wire [7:0] out_byte =
    (st_r == nfs_pkg::S_CMD1)  ? cmd1_byte :
    (st_r == nfs_pkg::S_ADDR)  ? addr_byte :
    (st_r == nfs_pkg::S_CMD2)  ? cmd2_byte :
    (st_r == nfs_pkg::S_STCMD) ? `NFS_CMD_STAT : wd_r;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wt_nxt   = wt_end ? wt_r : wt_r - 20'h1;
    stat_nxt = stat_r;
    tmo_nxt  = 1'b0;
    unique case (st_r)
      nfs_pkg::S_IDLE: if (take) begin
        st_nxt   = refuse ? nfs_pkg::S_DONE : nfs_pkg::S_CMD1;
        cnt_nxt  = (cmd_op == nfs_pkg::OP_ERASE) ? 12'h2 : 12'h0;
        wt_nxt   = 20'(`NFS_ADL_CYC);
        stat_nxt = 1'b0;
      end
      nfs_pkg::S_CMD1: if (ph_end) begin
        st_nxt = (op_r == nfs_pkg::OP_RESET) ? nfs_pkg::S_WB : nfs_pkg::S_ADDR;
        wt_nxt = 20'(`NFS_WB_CYC);
      end
      nfs_pkg::S_ADDR: if (ph_end) begin
        cnt_nxt = cnt_r + 12'h1;
        if (cnt_r == 12'h4) begin
          cnt_nxt = 12'h0;
          st_nxt  = (op_r == nfs_pkg::OP_PROG) ? nfs_pkg::S_GAP : nfs_pkg::S_CMD2;
          wt_nxt  = 20'(`NFS_ADL_CYC);
        end
      end
      nfs_pkg::S_GAP: if (wt_end) begin
        st_nxt = stat_r ? nfs_pkg::S_STRD : nfs_pkg::S_WDAT;
      end
      nfs_pkg::S_WDAT: if (ph_end) begin
        cnt_nxt = cnt_r + 12'h1;
        if (cnt_r == last_r) st_nxt = nfs_pkg::S_CMD2;
      end
      nfs_pkg::S_CMD2: if (ph_end) begin
        st_nxt = nfs_pkg::S_WB;
        wt_nxt = 20'(`NFS_WB_CYC);
      end
      nfs_pkg::S_WB: if (wt_end) begin
        st_nxt = nfs_pkg::S_BUSY;
        wt_nxt = busy_lim;
      end
      nfs_pkg::S_BUSY: if (rb_s) begin
        cnt_nxt = 12'h0;
        wt_nxt  = 20'(`NFS_ADL_CYC);
        st_nxt  = is_pe(op_r) ? nfs_pkg::S_STCMD :
                  (op_r == nfs_pkg::OP_RESET) ? nfs_pkg::S_DONE : nfs_pkg::S_RDAT;
      end else if (wt_end) begin
        st_nxt  = nfs_pkg::S_DONE;
        wt_nxt  = 20'(`NFS_ADL_CYC);
        tmo_nxt = 1'b1;
      end
      nfs_pkg::S_RDAT: if (ph_end) begin
        cnt_nxt = cnt_r + 12'h1;
        if (cnt_r == last_r) begin
          st_nxt = nfs_pkg::S_DONE;
          wt_nxt = 20'(`NFS_ADL_CYC);
        end
      end
      nfs_pkg::S_STCMD: if (ph_end) begin
        st_nxt   = nfs_pkg::S_GAP;
        wt_nxt   = 20'(`NFS_ADL_CYC);
        stat_nxt = 1'b1;
      end
      nfs_pkg::S_STRD: if (ph_end) begin
        st_nxt = nfs_pkg::S_DONE;
        wt_nxt = 20'(`NFS_ADL_CYC);
      end
      nfs_pkg::S_DONE: if (wt_end) st_nxt = nfs_pkg::S_IDLE;
      default: st_nxt = nfs_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_r   <= nfs_pkg::S_IDLE;
      {cnt_r, wt_r, ph_r, stat_r} <= 38'h0;
    end else if (ce) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wt_r   <= wt_nxt;
      stat_r <= stat_nxt;
      ph_r   <= (!(wr_st | rd_st) || ph_end) ? 5'h0 : (stall ? ph_r : ph_r + 5'h1);
    end
  end

  // ****************************************
  // Command capture, partial-program count, results
  // ****************************************
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      op_r <= nfs_pkg::OP_READ;
      {blk_r, page_r, col_r, last_r, wd_r} <= 49'h0;
      nop_addr_r <= 17'h0;
      nop_cnt_r  <= 3'h0;
      {res_fail, res_timeout, res_refused} <= 3'h0;
    end else if (ce) begin
      if (take) begin
        op_r   <= cmd_op;
        blk_r  <= cmd_block;
        page_r <= cmd_page;
        col_r  <= (cmd_op == nfs_pkg::OP_SCAN) ? `NFS_MARK_COL : cmd_col;
        last_r <= ((cmd_op == nfs_pkg::OP_SCAN) || cmd_len == 12'h0) ? 12'h0 :
                  cmd_len - 12'h1;
        {res_fail, res_timeout, res_refused} <= {2'h0, refuse};
        if (!refuse && cmd_op == nfs_pkg::OP_PROG) begin
          nop_addr_r <= {cmd_block, cmd_page};
          nop_cnt_r  <= same_pg ? nop_cnt_r + 3'h1 : 3'h1;
        end
        if (!refuse && cmd_op == nfs_pkg::OP_ERASE &&
            nop_addr_r[16:6] == cmd_block) nop_cnt_r <= 3'h0;
      end
      if (wr_take) wd_r <= wr_data;
      if (tmo_nxt) res_timeout <= 1'b1;
      if (mark_bad) res_fail <= 1'b1;
    end
  end

  // Invalid-block table, consulted before every program or erase
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int i = 0; i < `NFS_NBLK; i++) bad_tbl[i] <= 1'b0;
    end else if (mark_bad) begin
      bad_tbl[blk_r] <= 1'b1;
    end
  end

  // ****************************************
  // Pin registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {cle, ale, io_oe, wp_n, rd_valid} <= 5'h0;
      {ce_n, we_n, read_strobe_n} <= 3'h7;
      {io_out, rd_data} <= 16'h0;
    end else if (ce) begin
      cle  <= (st_r == nfs_pkg::S_CMD1) | (st_r == nfs_pkg::S_CMD2) |
              (st_r == nfs_pkg::S_STCMD);
      ale  <= st_r == nfs_pkg::S_ADDR;
      ce_n <= idle;
      we_n <= ~(wr_st & lo & ~stall);
      read_strobe_n <= ~(rd_st & lo);
      io_oe  <= wr_st;
      io_out <= out_byte;
      wp_n   <= ~idle & is_pe(op_r);
      rd_valid <= rd_take;
      if (smp) rd_data <= io_s;
    end
  end

  // ****************************************
  // Code over written and read bytes
  // ****************************************
  nfs_ecc u_ecc (
    .clk        (clk),
    .rst_n      (rst_s_n),
    .ce         (ce),
    .clr        (take),
    .in_valid   (wr_take | (ce & rd_take)),
    .in_byte    (rd_take ? io_s : wr_data),
    .code       (ecc_code),
    .code_valid (ecc_valid)
  );
endmodule
`default_nettype wire

// File: bench/nfs_flash_model.sv
// Behavioural 8-bit NAND device on the far side of the host sequencer
// Assumes host strobes on its pins; fail_next and hang come from the bench
`timescale 1ns/100ps
`default_nettype none
module nfs_flash_model #(
  parameter int BAD_BLK = 5,
  parameter int T_BUSY  = 400
) (
  // Host pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io_out,
  // Device pins
  output logic [7:0]      dq,
  output logic            rb_n,
  // Commanded faults
  input  wire logic       fail_next,
  input  wire logic       hang
);
  logic [7:0]  mem [logic [28:0]];
  logic [7:0]  pend [logic [28:0]];
  logic [7:0]  ad [5];
  logic [7:0]  st;
  logic [28:0] ptr;
  int          n;
  bit          stat;
  wire  [28:0] key = {ad[4][0], ad[3], ad[2], ad[1][3:0], ad[0]};
  initial begin
    dq = 8'h5a;
    rb_n = 1'b1;
    st = 8'hc0;
    n = 0;
    mem[{11'(BAD_BLK), 6'h01, 12'h800}] = 8'h00;
  end
  // Busy times are scaled well below the host's shortened limits
  task automatic busy();
    #50 rb_n = 1'b0;
    #(T_BUSY);
    wait (!hang);
    rb_n = 1'b1;
  endtask
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      stat = (io_out == 8'h70);
      case (io_out)
        8'h00, 8'h60, 8'h80: n = 0;
        8'h30: busy();
        8'h10: begin
          st = fail_next ? 8'hc1 : 8'hc0;
          if (!fail_next) foreach (pend[k]) mem[k] = pend[k];
          pend.delete();
          busy();
        end
        8'hd0, 8'hff: busy();
        // First-plane confirm: dummy busy, kept under 1 us by T_BUSY
        8'h11: busy();
        default: ;
      endcase
    end else if (!ce_n && ale && n < 5) begin
      ad[n] = io_out;
      n++;
      if (n == 5) ptr = key;
    end else if (!ce_n && !ale) begin
      pend[ptr] = io_out;
      ptr++;
    end
  end
  always @(negedge read_strobe_n)
    if (!ce_n) dq <= #20 stat ? st : (mem.exists(ptr) ? mem[ptr] : 8'hff);
  // Released bus shows the inverse of the last byte, not a stale copy
  always @(posedge read_strobe_n) begin
    if (!stat) ptr++;
    #15 dq = ~dq;
  end
endmodule
`default_nettype wire

// File: bench/nfs_host_sva.sv
// Checker for the NAND host sequencer command port and flash pins
// Assumes it is bound to nfs_host and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module nfs_host_sva (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  // Command port
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire nfs_pkg::nfs_op_t cmd_op,
  input wire logic             done,
  input wire logic             res_refused,
  // Flash pins
  input wire logic             cle,
  input wire logic             ale,
  input wire logic             ce_n,
  input wire logic             we_n,
  input wire logic             read_strobe_n,
  input wire logic             rb_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       we_q_r;
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  wire        take      = cmd_valid && cmd_ready && ce;
  wire        addr_rise = we_n && !we_q_r && ale;
  wire        data_rise = we_n && !we_q_r && !ale && !cle && !ce_n;
  // Cycles since the last address strobe rose, saturating
  assign gap_nxt = addr_rise ? 8'h00 : gap_r + {7'h00, gap_r != 8'hff};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_q_r <= 1'b1;
      gap_r  <= 8'hff;
    end else begin
      we_q_r <= we_n;
      gap_r  <= gap_nxt;
    end
  end
  // ****************
  // Assertions
  // ****************
  a_addr_data_gap: assert property (data_rise |-> gap_r >= 8'h18)
    else $error("data strobe too close to address strobe");
  a_latch_steady: assert property (!we_n && !$past(we_n) |->
      $stable(cle) && $stable(ale) && $stable(ce_n))
    else $error("latch control moved during strobe");
  a_latch_exclusive: assert property (!we_n |-> !(cle && ale))
    else $error("command and address latch both high");
  a_busy_quiet: assert property (!rb_n [*3] |-> we_n && read_strobe_n)
    else $error("strobe while device busy");
  a_ready_waits: assert property (!$past(rb_n) && !$past(rb_n, 2) |-> !cmd_ready)
    else $error("ready while device busy");
  a_one_at_time: assert property (take |=> !cmd_ready [*8])
    else $error("ready during command");
  a_refused_quiet: assert property (res_refused |-> we_n && read_strobe_n)
    else $error("strobe after refusal");
  a_refused_done: assert property (take && cmd_op > nfs_pkg::OP_SCAN |=>
      res_refused ##[23:26] done)
    else $error("refused command not finished on time");
endmodule
bind nfs_host nfs_host_sva nfs_host_sva_i (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .done(done), .res_refused(res_refused), .cle(cle), .ale(ale),
  .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n), .rb_n(rb_n)
);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the NAND host sequencer with a device model
// Assumes nfs_flash_model on the pins and the checker bound to nfs_host
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {
    nfs_pkg::nfs_op_t op;
    logic [10:0]      b;
    logic [5:0]       p;
    logic [11:0]      l;
    logic [7:0]       d;
    logic [2:0]       e;
  } nfs_row_t;
  logic             clk, cmd_ready, wr_ready, rd_valid, done, res_fail, res_timeout;
  logic             res_refused, ecc_valid, cle, ale, ce_n, we_n, read_strobe_n, wp_n;
  logic             io_oe, rb_n;
  logic             rst_n = 1'b0, cmd_valid = 1'b0, fail_next = 1'b0, hang = 1'b0;
  logic             ce = 1'b1, wr_valid = 1'b1;
  nfs_pkg::nfs_op_t cmd_op = nfs_pkg::OP_READ;
  logic [10:0]      cmd_block = 11'h000;
  logic [5:0]       cmd_page = 6'h00;
  logic [11:0]      cmd_len = 12'h001;
  logic [11:0]      cmd_col = 12'h000;
  logic [23:0]      ecc_code;
  logic [7:0]       wr_data = 8'h00;
  logic [7:0]       rd_data, io_out, dq;
  logic [7:0]       rq [$];
  int               n_ecc, fail_count, samples_checked;
  // Rows: op, block, page, length, data base, {fail, refused, code pulses}
  nfs_row_t rows [10] = '{
    '{nfs_pkg::OP_SCAN,  11'h005, 6'h01, 12'h001, 8'hff, 3'h4},
    '{nfs_pkg::OP_SCAN,  11'h006, 6'h01, 12'h001, 8'hff, 3'h0},
    '{nfs_pkg::OP_PROG,  11'h005, 6'h00, 12'h004, 8'h40, 3'h2},
    '{nfs_pkg::OP_ERASE, 11'h005, 6'h00, 12'h001, 8'hff, 3'h2},
    '{nfs_pkg::OP_READ,  11'h006, 6'h00, 12'h200, 8'hff, 3'h1},
    '{nfs_pkg::OP_PROG,  11'h007, 6'h02, 12'h004, 8'h10, 3'h0},
    '{nfs_pkg::OP_READ,  11'h007, 6'h02, 12'h004, 8'h10, 3'h0},
    '{nfs_pkg::OP_RESET, 11'h000, 6'h00, 12'h001, 8'hff, 3'h0},
    '{nfs_pkg::OP_PROG,  11'h009, 6'h00, 12'h004, 8'h30, 3'h0},
    '{nfs_pkg::nfs_op_t'(3'h5), 11'h000, 6'h00, 12'h001, 8'hff, 3'h2}};
  wire [7:0]        io_in = io_oe ? io_out : dq;
  nfs_host #(.P_READ_CYC(200), .P_PROG_CYC(200), .P_ERASE_CYC(200), .P_RST_CYC(200)) nfs_host_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_page(cmd_page), .cmd_col(cmd_col),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .res_fail(res_fail),
    .res_timeout(res_timeout), .res_refused(res_refused), .ecc_code(ecc_code),
    .ecc_valid(ecc_valid), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .rb_n(rb_n));
  nfs_flash_model nfs_flash_model_i (
    .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n),
    .io_out(io_out), .dq(dq), .rb_n(rb_n), .fail_next(fail_next), .hang(hang));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_ready && wr_valid && ce) wr_data <= wr_data + 8'h01;
    if (rd_valid && ce) rq.push_back(rd_data);
    if (ecc_valid) n_ecc++;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("%0d compared, %0d mismatched", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_hi(input bit on_done);
    for (int t = 0; t < 20000; t++) begin
      @(negedge clk);
      if ((on_done ? done : cmd_ready) === 1'b1) return;
    end
    fail_count++;
    end_sim();
  endtask
  task automatic do_cmd(input nfs_row_t r);
    wait_hi(1'b0);
    @(posedge clk);
    rq.delete();
    n_ecc = 0;
    wr_data <= r.d;
    cmd_op <= r.op;
    cmd_block <= r.b;
    cmd_page <= r.p;
    cmd_len <= r.l;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    wait_hi(1'b1);
  endtask
  task automatic run_row(input nfs_row_t r);
    do_cmd(r);
    check(res_fail, r.e[2]);
    check(res_refused, r.e[1]);
    check(res_timeout, 1'b0);
    check(n_ecc, r.e[0]);
    // All-erased run: every byte and column parity is even
    if (r.e[0]) check(ecc_code, 24'h000000);
    if (r.op == nfs_pkg::OP_READ) begin
      check(rq.size(), r.l);
      foreach (rq[j]) check(rq[j], r.d == 8'hff ? r.d : r.d + 8'(j));
    end
    $display("test op %0d block %0d ended", r.op, r.b);
  endtask
  // Pins and done while reset is applied
  task automatic pins_idle();
    @(negedge clk);
    check({cle, ale, io_oe, wp_n, ce_n, we_n, read_strobe_n, done}, 8'h0e);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    pins_idle();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[k]) run_row(rows[k]);
    for (int i = 0; i < 5; i++)
      run_row('{nfs_pkg::OP_PROG, 11'h007, 6'h03, 12'h004, 8'h20, (i == 4) ? 3'h2 : 3'h0});
    run_row('{nfs_pkg::OP_ERASE, 11'h007, 6'h00, 12'h001, 8'hff, 3'h0});
    run_row('{nfs_pkg::OP_PROG, 11'h007, 6'h03, 12'h004, 8'h20, 3'h0});
    @(posedge clk) fail_next <= 1'b1;
    run_row('{nfs_pkg::OP_PROG, 11'h009, 6'h01, 12'h004, 8'h50, 3'h4});
    @(posedge clk) fail_next <= 1'b0;
    run_row('{nfs_pkg::OP_PROG, 11'h009, 6'h02, 12'h004, 8'h50, 3'h2});
    run_row('{nfs_pkg::OP_ERASE, 11'h009, 6'h00, 12'h001, 8'hff, 3'h2});
    run_row('{nfs_pkg::OP_READ, 11'h009, 6'h00, 12'h004, 8'h30, 3'h0});
    // Enable dropped mid-command, then write data withheld for a few beats
    fork
      run_row('{nfs_pkg::OP_PROG, 11'h00a, 6'h00, 12'h004, 8'h60, 3'h0});
      begin
        repeat (100) @(posedge clk);
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        repeat (30) @(posedge clk);
        wr_valid <= 1'b0;
        repeat (40) @(posedge clk);
        wr_valid <= 1'b1;
      end
    join
    @(posedge clk) cmd_col <= 12'h001;
    run_row('{nfs_pkg::OP_READ, 11'h00a, 6'h00, 12'h003, 8'h61, 3'h0});
    @(posedge clk) cmd_col <= 12'h000;
    $display("test enable, stall and column ended");
    @(posedge clk) hang <= 1'b1;
    do_cmd('{nfs_pkg::OP_READ, 11'h006, 6'h00, 12'h001, 8'hff, 3'h0});
    check(res_timeout, 1'b1);
    @(posedge clk) hang <= 1'b0;
    $display("test busy timeout ended");
    fork
      do_cmd('{nfs_pkg::OP_READ, 11'h006, 6'h00, 12'h001, 8'hff, 3'h0});
      begin
        repeat (60) @(posedge clk);
        rst_n <= 1'b0;
      end
    join_any
    disable fork;
    pins_idle();
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    run_row('{nfs_pkg::OP_READ, 11'h006, 6'h00, 12'h004, 8'hff, 3'h0});
    $display("test reset in mid command ended");
    end_sim();
  end
endmodule
`default_nettype wire
